// ---- dci_cmd.sv ----
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
// What this block does
// R1: address request returns cylinder hi, lo, head, sector bytes; completion byte 00H.
// R2: after an aborted transfer or verify the address points at the failing sector.
// R3: host sends at most 512 loopback bytes, properly addressed.
// R4: loopback read returns the bytes taken by loopback write.
// R5: loopback leaves completion byte and status fields alone.
// R6: seek stores address, moves heads, enables parallel poll on arrival.
// R7: status right after seek end reads 1FH primary, 01H completion.
// R8: unit not ready or unavailable at seek gives 13H, 01H at once.
// R9: after seek only seek check shows; miscompares wait for next data access.
// R10: universal clear returns the block to its hard clear state; the parameter and count registers and the loopback length keep their values.
// R11: address record loads four bytes, no unit command, status 00H, 00H.
// R12: auto-seek bit seeks at end of cylinder, downward when direction is 1.
// R13: cylinder bit spans all surfaces; clear means one surface per cylinder.
// R14: spare track seeking only while sparing bit is set.
// R15: end operation disables parallel poll and returns to command polling.
// R16: wakeup waits for a reserved unit to free; always 17H, 01H.
// R17: verify checks header, then sector data, stops at error or count, no data out.
// R18: fast read streams 256-byte sectors until untalk, partial last sector allowed.
// R19: host should untalk promptly or the address runs ahead.
// R20: overrun, data or unit error aborts with dummy end byte, 01H; normal 00H.
// R21: slow read buffers a sector, then enables parallel poll for 256 bytes.
// R22: overrun is detected and reported as 0EH at end of the sector.
// R23: file mask bits persist until next set-mask or clear.
module dci_cmd
  import dci_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        univ_clear,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  input  wire logic        unlisten,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  output logic             tx_eot,
  input  wire logic        tx_ready,
  input  wire logic        untalk,
  output logic             ppoll_en,
  input  wire logic        unit_ready,
  input  wire logic        unit_reserved,
  input  wire logic        seek_arrived,
  input  wire logic        seek_check,
  output logic             seek_start,
  output logic      [31:0] seek_addr,
  input  wire logic        hdr_cyl_ok,
  input  wire logic        hdr_hs_ok,
  output logic             xfer_go,
  input  wire logic [7:0]  rd_byte,
  input  wire logic        rd_valid,
  input  wire logic        rd_data_err,
  input  wire logic        rd_unit_err,
  input  wire logic        spare_req
);
  // ****************************************
  // declarations
  // ****************************************
  dci_state_t  st_q, st_d;
  logic [7:0]  s1_q, s1_d, dsj_q, dsj_d, dsw_q, dsw_d, txb_q, txb_d;
  logic [3:0]  mask_q, mask_d;
  logic [9:0]  idx_q, idx_d, len_q, len_d;
  logic [15:0] cnt_q, cnt_d, count_q, count_d, geom_q, geom_d;
  logic [31:0] param_q, param_d, prdata_q, prdata_d, laddr;
  logic        ppoll_q, ppoll_d, ovr_q, ovr_d, cmis_q, cmis_d, hmis_q, hmis_d;
  logic        txv_q, txv_d, txe_q, txe_d, go_q, go_d, sk_q, sk_d;
  logic        la_load, la_step, at_eoc, mem_we, tx_free, sec_end, mapped;
  logic        apb_wr, cmd_go, fast_op;
  logic [8:0]  mem_wa;
  logic [7:0]  mem_wd, abyte, lb_rdata;
  logic [3:0]  cmd_op;
  logic [7:0]  lb_mem [0:511];

  // ****************************************
  // register bus
  // ****************************************
  assign apb_wr  = psel && penable && pwrite;
  assign cmd_go  = apb_wr && paddr == A_CMD && st_q == ST_IDLE;  // busy drops commands
  assign cmd_op  = pwdata[3:0];
  assign mapped  = paddr == A_CMD || paddr == A_PARAM || paddr == A_COUNT ||
                   paddr == A_STAT || paddr == A_LADDR || paddr == A_GEOM ||
                   paddr == A_MASK;
  assign pready  = 1'b1;  // zero wait state
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // read data is caught in the setup phase so the access phase sees a flop
  always_comb begin
    param_d  = param_q;
    count_d  = count_q;
    geom_d   = geom_q;
    prdata_d = prdata_q;
    if (univ_clear) begin
      geom_d = GEOM_RST;  // [R10]
    end else if (apb_wr) begin
      if (paddr == A_PARAM)      param_d = pwdata;
      else if (paddr == A_COUNT) count_d = pwdata[15:0];
      else if (paddr == A_GEOM)  geom_d  = pwdata[15:0];
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == A_PARAM)      prdata_d = param_q;
      else if (paddr == A_COUNT) prdata_d = {16'h0000, count_q};
      else if (paddr == A_STAT)  prdata_d = {4'h0, hmis_q, cmis_q, ppoll_q,
                                             st_q != ST_IDLE, dsw_q, dsj_q, s1_q};
      else if (paddr == A_LADDR) prdata_d = laddr;
      else if (paddr == A_GEOM)  prdata_d = {16'h0000, geom_q};
      else if (paddr == A_MASK)  prdata_d = {28'h0000000, mask_q};
      else                       prdata_d = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_q  <= '0;
      count_q  <= '0;
      geom_q   <= GEOM_RST;
      prdata_q <= '0;
    end else begin
      param_q  <= param_d;
      count_q  <= count_d;
      geom_q   <= geom_d;
      prdata_q <= prdata_d;
    end
  end

  // ****************************************
  // logical address and buffer
  // ****************************************
  dci_laddr u_laddr (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (univ_clear),
    .load      (la_load),
    .load_val  (param_q),
    .step      (la_step),
    .mask      (mask_q),
    .last_head (geom_q[7:0]),
    .last_sec  (geom_q[15:8]),
    .laddr_q   (laddr),
    .at_eoc    (at_eoc)
  );

  // one buffer serves loopback and the slow read sector
  always_ff @(posedge pclk) begin
    if (mem_we) lb_mem[mem_wa] <= mem_wd;
  end
  assign lb_rdata = lb_mem[idx_q[8:0]];

  assign tx_free = !txv_q || tx_ready;
  assign sec_end = rd_valid && idx_q == SEC_LAST;
  assign fast_op = cmd_op == OP_HS_READ;
  always_comb begin
    case (idx_q[1:0])
      2'd0:    abyte = laddr[15:8];
      2'd1:    abyte = laddr[7:0];
      2'd2:    abyte = laddr[23:16];
      default: abyte = laddr[31:24];
    endcase
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_comb begin
    st_d = st_q; s1_d = s1_q; dsj_d = dsj_q; dsw_d = dsw_q;
    mask_d = mask_q; ppoll_d = ppoll_q; idx_d = idx_q; len_d = len_q;
    cnt_d = cnt_q; ovr_d = ovr_q; cmis_d = cmis_q; hmis_d = hmis_q;
    txb_d = txb_q; txv_d = txv_q && !tx_ready; txe_d = txe_q;
    go_d = go_q; sk_d = 1'b0;
    la_load = 1'b0; la_step = 1'b0;
    mem_we = 1'b0; mem_wa = idx_q[8:0]; mem_wd = rd_byte;
    if (univ_clear) begin
      st_d = ST_IDLE; s1_d = S1_OK; dsj_d = DSJ_OK; dsw_d = 8'h00;  // [R10]
      mask_d = MASK_RST; ppoll_d = 1'b0; txv_d = 1'b0; go_d = 1'b0;  // [R10] [R23]
      ovr_d = 1'b0; cmis_d = 1'b0; hmis_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cmd_go) begin
            ppoll_d = 1'b0;  // [R15]
            idx_d   = '0;
            case (cmd_op)
              OP_REQ_ADDR: st_d = ST_ADDR_TX;
              OP_LB_WR: begin
                st_d  = ST_LB_WR;
                len_d = '0;
              end
              OP_LB_RD: st_d = ST_LB_RD;
              OP_SEEK: begin
                if (!unit_ready || unit_reserved) begin
                  s1_d = S1_ST2; dsj_d = DSJ_ERR; ppoll_d = 1'b1;  // [R8]
                end else begin
                  la_load = 1'b1;  // [R6]
                  sk_d    = 1'b1;  // [R6]
                  cmis_d  = 1'b0;  // [R9]
                  hmis_d  = 1'b0;  // [R9]
                  dsw_d[DSW_SEEK_CHK] = 1'b0;
                  st_d    = ST_SEEK;
                end
              end
              OP_ADDR_REC: begin
                la_load = 1'b1;  // [R11]
                s1_d = S1_OK; dsj_d = DSJ_OK;  // [R11]
              end
              OP_SET_MASK: begin
                mask_d = param_q[3:0];  // [R23]
                s1_d = S1_OK; dsj_d = DSJ_OK;
              end
              OP_END: st_d = ST_IDLE;  // [R15]
              OP_WAKE: begin
                if (unit_reserved) st_d = ST_WAKE;
                else begin
                  s1_d = S1_UNAV; dsj_d = DSJ_ERR;  // [R16]
                end
              end
              OP_VERIFY, OP_HS_READ, OP_LS_READ: begin
                // miscompares are only picked up on a data access
                cmis_d = !hdr_cyl_ok;  // [R9]
                hmis_d = !hdr_hs_ok;  // [R9]
                ovr_d  = 1'b0;
                if (!hdr_cyl_ok || !hdr_hs_ok) begin
                  s1_d  = !hdr_cyl_ok ? S1_CYL : S1_HS;  // [R17]
                  dsj_d = DSJ_ERR;
                  st_d  = fast_op ? ST_EOT : ST_IDLE;  // [R20]
                end else begin
                  go_d  = 1'b1;
                  cnt_d = count_q;
                  st_d  = cmd_op == OP_VERIFY ? ST_VFY :
                          fast_op ? ST_HSR : ST_LSR_FILL;
                end
              end
              default: begin
                s1_d = S1_ILL; dsj_d = DSJ_ERR;
              end
            endcase
          end
        end
        ST_ADDR_TX: begin
          if (tx_free) begin
            if (idx_q == ADDR_BYTES) begin
              dsj_d = DSJ_OK;  // [R1]
              st_d  = ST_IDLE;
            end else begin
              txv_d = 1'b1;
              txb_d = abyte;  // [R1] [R2]
              txe_d = idx_q == ADDR_BYTES - 10'd1;
              idx_d = idx_q + 10'd1;
            end
          end
        end
        ST_LB_WR: begin
          // bytes past the buffer end are dropped; status stays untouched
          if (unlisten) st_d = ST_IDLE;  // [R5]
          else if (rx_valid && len_q < LB_DEPTH) begin
            mem_we = 1'b1;  // [R3]
            mem_wa = len_q[8:0];
            mem_wd = rx_byte;
            len_d  = len_q + 10'd1;
          end
        end
        ST_LB_RD: begin
          if (untalk) st_d = ST_IDLE;  // [R5]
          else if (tx_free && idx_q < len_q) begin
            txv_d = 1'b1;
            txb_d = lb_rdata;  // [R4]
            txe_d = idx_q == len_q - 10'd1;
            idx_d = idx_q + 10'd1;
          end
        end
        ST_SEEK: begin
          if (seek_arrived) begin
            s1_d = S1_ATTN; dsj_d = DSJ_ERR;  // [R7]
            dsw_d[DSW_SEEK_CHK] = seek_check;  // [R9]
            dsw_d[DSW_ATTN] = 1'b1;
            ppoll_d = 1'b1;  // [R6]
            st_d = ST_IDLE;
          end
        end
        ST_WAKE: begin
          if (!unit_reserved) begin
            s1_d = S1_UNAV; dsj_d = DSJ_ERR; st_d = ST_IDLE;  // [R16]
          end
        end
        ST_VFY: begin
          // no byte reaches the host; address stops on the bad sector
          if (rd_data_err) begin
            s1_d = S1_DATA; dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_IDLE;  // [R17] [R2]
          end else if (sec_end) begin
            idx_d = '0;
            la_step = 1'b1;
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001) begin
              s1_d = S1_OK; dsj_d = DSJ_OK; go_d = 1'b0; st_d = ST_IDLE;  // [R17]
            end else if (at_eoc && !mask_q[MB_A]) begin
              s1_d = S1_EOC; dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_IDLE;
            end else if (at_eoc) sk_d = 1'b1;  // [R12]
          end else if (rd_valid) idx_d = idx_q + 10'd1;
        end
        ST_HSR: begin
          if (untalk) begin
            s1_d = S1_OK; dsj_d = DSJ_OK; go_d = 1'b0; st_d = ST_IDLE;  // [R18] [R20]
          end else if (rd_data_err || rd_unit_err) begin
            s1_d  = rd_data_err ? S1_DATA : S1_ST2;  // [R20]
            dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_EOT;  // [R20]
          end else if (spare_req) begin
            if (mask_q[MB_S]) sk_d = 1'b1;  // [R14]
            else begin
              s1_d = S1_DEF; dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_EOT;  // [R14]
            end
          end else if (rd_valid) begin
            if (!tx_free) ovr_d = 1'b1;  // [R22]
            else begin
              txv_d = 1'b1; txb_d = rd_byte; txe_d = 1'b0;  // [R18]
            end
            if (sec_end) begin
              idx_d = '0;
              if (ovr_q || !tx_free) begin
                s1_d = S1_OVR; dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_EOT;  // [R22]
              end else begin
                la_step = 1'b1;  // [R18]
                if (at_eoc && !mask_q[MB_A]) begin
                  s1_d = S1_EOC; dsj_d = DSJ_ERR; go_d = 1'b0; st_d = ST_EOT;
                end else if (at_eoc) sk_d = 1'b1;  // [R12]
              end
            end else idx_d = idx_q + 10'd1;
          end
        end
        ST_EOT: begin
          if (tx_free) begin
            txv_d = 1'b1; txb_d = DUMMY_BYTE; txe_d = 1'b1; st_d = ST_IDLE;  // [R20]
          end
        end
        ST_LSR_FILL: begin
          if (rd_data_err || rd_unit_err) begin
            s1_d = rd_data_err ? S1_DATA : S1_ST2; dsj_d = DSJ_ERR;
            go_d = 1'b0; ppoll_d = 1'b1; st_d = ST_IDLE;
          end else if (rd_valid) begin
            mem_we = 1'b1;  // [R21]
            if (sec_end) begin
              go_d = 1'b0; ppoll_d = 1'b1; la_step = 1'b1;  // [R21]
              idx_d = '0; st_d = ST_LSR_TX;
            end else idx_d = idx_q + 10'd1;
          end
        end
        ST_LSR_TX: begin
          if (untalk || (idx_q == SEC_BYTES && tx_free)) begin
            s1_d = S1_OK; dsj_d = DSJ_OK; st_d = ST_IDLE;
          end else if (tx_free && idx_q < SEC_BYTES) begin
            txv_d = 1'b1; txb_d = lb_rdata;  // [R21]
            txe_d = idx_q == SEC_LAST;
            idx_d = idx_q + 10'd1;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE; s1_q <= S1_OK; dsj_q <= DSJ_OK; dsw_q <= 8'h00;
      mask_q <= MASK_RST; ppoll_q <= 1'b0; idx_q <= '0; len_q <= '0;
      cnt_q <= '0; ovr_q <= 1'b0; cmis_q <= 1'b0; hmis_q <= 1'b0;
      txb_q <= 8'h00; txv_q <= 1'b0; txe_q <= 1'b0; go_q <= 1'b0; sk_q <= 1'b0;
    end else begin
      st_q <= st_d; s1_q <= s1_d; dsj_q <= dsj_d; dsw_q <= dsw_d;
      mask_q <= mask_d; ppoll_q <= ppoll_d; idx_q <= idx_d; len_q <= len_d;
      cnt_q <= cnt_d; ovr_q <= ovr_d; cmis_q <= cmis_d; hmis_q <= hmis_d;
      txb_q <= txb_d; txv_q <= txv_d; txe_q <= txe_d; go_q <= go_d; sk_q <= sk_d;
    end
  end

  assign tx_byte    = txb_q;
  assign tx_valid   = txv_q;
  assign tx_eot     = txe_q;
  assign ppoll_en   = ppoll_q;
  assign xfer_go    = go_q;
  assign seek_start = sk_q;
  assign seek_addr  = laddr;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_addr_done: assert property (  // [R1]
    (st_q == ST_ADDR_TX && st_d == ST_IDLE && !univ_clear) |=> dsj_q == DSJ_OK)
    else $error("address request did not end with completion 00");
  chk_lb_quiet: assert property (  // [R5]
    (st_q == ST_LB_WR || st_q == ST_LB_RD) && !univ_clear |=> $stable(s1_q) && $stable(dsj_q))
    else $error("loopback changed status");
  chk_lb_echo: assert property (  // [R4]
    st_q == ST_LB_RD && !untalk && !univ_clear && tx_free && idx_q < len_q
    |=> tx_valid && tx_byte == $past(lb_rdata))
    else $error("loopback read byte differs from buffer");
  chk_seek_refuse: assert property (  // [R8]
    cmd_go && cmd_op == OP_SEEK && !univ_clear && !unit_ready
    |=> st_q == ST_IDLE && s1_q == S1_ST2 && dsj_q == DSJ_ERR && !seek_start)
    else $error("seek to unready unit not refused");
  chk_seek_end: assert property (  // [R7]
    st_q == ST_SEEK && seek_arrived && !univ_clear
    |=> s1_q == S1_ATTN && dsj_q == DSJ_ERR && ppoll_en)
    else $error("seek end status wrong");
  chk_wake_free: assert property (  // [R16]
    cmd_go && cmd_op == OP_WAKE && !unit_reserved && !univ_clear
    |=> st_q == ST_IDLE && s1_q == S1_UNAV && dsj_q == DSJ_ERR)
    else $error("wakeup on free unit wrong");
  chk_end_poll: assert property (  // [R15]
    cmd_go && cmd_op == OP_END |=> !ppoll_en && st_q == ST_IDLE)
    else $error("end did not drop parallel poll");
  chk_hsr_abort: assert property (  // [R20]
    st_q == ST_HSR && !untalk && !univ_clear && rd_data_err
    |=> st_q == ST_EOT && dsj_q == DSJ_ERR && !xfer_go)
    else $error("fast read error not aborted");
  chk_mask_hold: assert property (  // [R23]
    !(cmd_go && cmd_op == OP_SET_MASK) && !univ_clear |=> $stable(mask_q))
    else $error("file mask changed unasked");
  chk_arec_noseek: assert property (  // [R11]
    cmd_go && cmd_op == OP_ADDR_REC && !univ_clear
    |=> !seek_start && s1_q == S1_OK && laddr == $past(param_q))
    else $error("address record wrong");

  cov_seek_done: cover property (st_q == ST_SEEK ##1 st_q == ST_IDLE);
  cov_hsr_untalk: cover property (st_q == ST_HSR && untalk);
  cov_lb_read: cover property (st_q == ST_LB_RD && tx_valid && tx_ready && tx_eot);
  cov_vfy_ok: cover property (st_q == ST_VFY && sec_end && cnt_q == 16'h0001);
endmodule : dci_cmd

// ---- dci_pkg.sv ----
package dci_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_PARAM = 8'h04;
  localparam logic [7:0] A_COUNT = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0c;
  localparam logic [7:0] A_LADDR = 8'h10;
  localparam logic [7:0] A_GEOM  = 8'h14;
  localparam logic [7:0] A_MASK  = 8'h18;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int MB_A = 0;  // auto-seek at end of logical cylinder
  localparam int MB_C = 1;  // cylinder mode
  localparam int MB_S = 2;  // sparing allowed
  localparam int MB_D = 3;  // seek downward
  localparam int DSW_SEEK_CHK = 2;
  localparam int DSW_ATTN     = 7;
  localparam int ST_BUSY  = 24;
  localparam int ST_PPOLL = 25;
  localparam int ST_CMIS  = 26;
  localparam int ST_HMIS  = 27;
  localparam logic [3:0]  MASK_RST = 4'h0;
  localparam logic [15:0] GEOM_RST = 16'h2f04;  // last sector, last head

  // ****************************************
  // status codes and counts
  // ****************************************
  localparam logic [7:0] S1_OK   = 8'h00;
  localparam logic [7:0] S1_ILL  = 8'h01;
  localparam logic [7:0] S1_CYL  = 8'h07;
  localparam logic [7:0] S1_DATA = 8'h08;
  localparam logic [7:0] S1_HS   = 8'h09;
  localparam logic [7:0] S1_EOC  = 8'h0c;
  localparam logic [7:0] S1_OVR  = 8'h0e;
  localparam logic [7:0] S1_DEF  = 8'h11;
  localparam logic [7:0] S1_ST2  = 8'h13;
  localparam logic [7:0] S1_UNAV = 8'h17;
  localparam logic [7:0] S1_ATTN = 8'h1f;
  localparam logic [7:0] DSJ_OK  = 8'h00;
  localparam logic [7:0] DSJ_ERR = 8'h01;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [9:0] LB_DEPTH  = 10'd512;
  localparam logic [9:0] SEC_BYTES = 10'd256;
  localparam logic [9:0] SEC_LAST  = 10'd255;
  localparam logic [9:0] ADDR_BYTES = 10'd4;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_REQ_ADDR = 4'h1, OP_LB_WR = 4'h2, OP_LB_RD = 4'h3,
    OP_SEEK = 4'h4, OP_ADDR_REC = 4'h5, OP_SET_MASK = 4'h6, OP_END = 4'h7,
    OP_WAKE = 4'h8, OP_VERIFY = 4'h9, OP_HS_READ = 4'ha, OP_LS_READ = 4'hb
  } dci_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR_TX = 4'h1, ST_LB_WR = 4'h2, ST_LB_RD = 4'h3,
    ST_SEEK = 4'h4, ST_WAKE = 4'h5, ST_VFY = 4'h6, ST_HSR = 4'h7,
    ST_EOT = 4'h8, ST_LSR_FILL = 4'h9, ST_LSR_TX = 4'ha
  } dci_state_t;
endpackage : dci_pkg

// ---- dci_laddr.sv ----
`timescale 1ns/10ps
// ****************************************
// logical address counter
// ****************************************
module dci_laddr
  import dci_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        step,
  input  wire logic [3:0]  mask,
  input  wire logic [7:0]  last_head,
  input  wire logic [7:0]  last_sec,
  output logic      [31:0] laddr_q,
  output logic             at_eoc
);
  logic [31:0] laddr_d;
  logic [15:0] cyl;
  logic [7:0]  head;
  logic [7:0]  sec;

  assign {sec, head, cyl} = laddr_q;
  // end of logical cylinder depends on cylinder or surface mode
  assign at_eoc = (sec == last_sec) && (!mask[MB_C] || head == last_head);  // [R13]

  // next address on a completed sector
  always_comb begin
    laddr_d = laddr_q;
    if (clr) begin
      laddr_d = '0;
    end else if (load) begin
      laddr_d = load_val;
    end else if (step) begin
      if (sec != last_sec) begin
        laddr_d[31:24] = sec + 8'h01;
      end else begin
        laddr_d[31:24] = 8'h00;
        if (!at_eoc) begin
          laddr_d[23:16] = head + 8'h01;  // [R13]
        end else begin
          if (mask[MB_C]) laddr_d[23:16] = 8'h00;  // [R13]
          // surface mode stays on its surface
          if (mask[MB_A]) begin
            laddr_d[15:0] = mask[MB_D] ? cyl - 16'h0001 : cyl + 16'h0001;  // [R12]
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) laddr_q <= '0;
    else          laddr_q <= laddr_d;
  end
endmodule : dci_laddr

// ---- dci_host_model.sv ----
`timescale 1ns/10ps
// ****************************************
// host talker side
// ****************************************
module dci_host_model
  import dci_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  input  wire logic       tx_eot,
  output logic            tx_ready,
  output logic [7:0]      got_q [0:7],
  output logic [3:0]      cnt_q
);
  // ready every other cycle, so held bytes get exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'h0;
      cnt_q    <= 4'h0;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) begin
        got_q[cnt_q[2:0]] <= tx_byte;
        cnt_q             <= cnt_q + 4'h1;
      end
    end
  end
endmodule : dci_host_model

// ---- dci_cmd_tb_top.sv ----
`timescale 1ns/10ps
// ****************************************
// command bench
// ****************************************
module dci_cmd_tb_top
  import dci_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic univ_clear = 1'h0, rx_valid = 1'h0, unlisten = 1'h0, untalk = 1'h0, err;
  logic unit_ready = 1'h0, unit_reserved = 1'h0, seek_arrived = 1'h0, seek_check = 1'h0;
  logic hdr_cyl_ok = 1'h1, hdr_hs_ok = 1'h1, rd_valid = 1'h0, rd_data_err = 1'h0;
  logic rd_unit_err = 1'h0, spare_req = 1'h0, tx_ready, tx_valid, tx_eot, pready, pslverr;
  logic ppoll_en, seek_start, xfer_go;
  logic [7:0] paddr = 8'h00, rx_byte = 8'h00, rd_byte = 8'h00, tx_byte, got [0:7];
  logic [3:0] cnt;
  logic [31:0] pwdata = 32'h0, prdata, seek_addr, rdat;
  int mismatches = 0, samples_checked = 0, cyc = 0;

  dci_cmd u_dci_cmd (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .univ_clear, .rx_byte, .rx_valid, .unlisten, .tx_byte, .tx_valid,
    .tx_eot, .tx_ready, .untalk, .ppoll_en, .unit_ready, .unit_reserved, .seek_arrived,
    .seek_check, .seek_start, .seek_addr, .hdr_cyl_ok, .hdr_hs_ok, .xfer_go, .rd_byte,
    .rd_valid, .rd_data_err, .rd_unit_err, .spare_req);
  dci_host_model u_dci_host_model (.pclk, .presetn, .tx_byte, .tx_valid, .tx_eot,
    .tx_ready, .got_q(got), .cnt_q(cnt));

  // 8 ns clock
  always #4 pclk = ~pclk;

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);  // one idle edge, so psel is never set twice in a step
  endtask : apb

  // poll status until the command has finished
  task automatic wt;
    apb(1'h0, A_STAT, 32'h0);
    while (rdat[ST_BUSY] !== 1'h0) apb(1'h0, A_STAT, 32'h0);
  endtask : wt

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // hang guard, well above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end

  // ****************************************
  // command sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h1, A_PARAM, 32'h0502_0010);
    apb(1'h1, A_CMD, 32'h5);
    wt;
    chk(32'(rdat[15:0]), 32'h0);
    apb(1'h0, A_LADDR, 32'h0);
    chk(rdat, 32'h0502_0010);
    apb(1'h1, A_CMD, 32'h1);
    wt;
    chk({got[0], got[1], got[2], got[3]}, 32'h0010_0205);
    chk(32'(rdat[15:8]), 32'(DSJ_OK));
    apb(1'h1, A_CMD, 32'h4);
    wt;
    chk(32'(rdat[15:0]), 32'h0113);
    // three bytes, far under the buffer limit
    apb(1'h1, A_CMD, 32'h2);
    for (int i = 0; i < 3; i++) begin
      rx_byte <= 8'ha0 + 8'(i);
      rx_valid <= 1'h1;
      @(posedge pclk);
    end
    rx_valid <= 1'h0;
    unlisten <= 1'h1;
    @(posedge pclk);
    unlisten <= 1'h0;
    apb(1'h1, A_CMD, 32'h3);
    // loopback read only ends on untalk, once all three bytes are taken
    while (cnt !== 4'h7) @(posedge pclk);
    untalk <= 1'h1;
    @(posedge pclk);
    untalk <= 1'h0;
    wt;
    chk({got[4], got[5], got[6]}, 32'ha0a1a2);
    chk(32'(rdat[15:0]), 32'h0113);
    unit_reserved <= 1'h1;
    apb(1'h1, A_CMD, 32'h8);
    apb(1'h0, A_STAT, 32'h0);
    chk(32'(rdat[ST_BUSY]), 32'h1);
    unit_reserved <= 1'h0;
    wt;
    chk(32'(rdat[15:0]), 32'h0117);
    unit_ready <= 1'h1;
    apb(1'h1, A_PARAM, 32'h0301_0020);
    apb(1'h1, A_CMD, 32'h4);
    while (seek_start !== 1'h1) @(posedge pclk);
    chk(seek_addr, 32'h0301_0020);
    seek_check <= 1'h1;
    seek_arrived <= 1'h1;
    @(posedge pclk);
    seek_arrived <= 1'h0;
    wt;
    chk(32'(rdat[27:0]), 32'h284_011f);
    chk(32'(ppoll_en), 32'h1);
    apb(1'h1, A_CMD, 32'h7);
    wt;
    chk(32'(ppoll_en), 32'h0);
    apb(1'h1, A_COUNT, 32'h1);
    apb(1'h1, A_CMD, 32'h9);
    while (xfer_go !== 1'h1) @(posedge pclk);
    rd_data_err <= 1'h1;
    @(posedge pclk);
    rd_data_err <= 1'h0;
    wt;
    chk(32'(rdat[15:0]), 32'h0108);
    apb(1'h0, A_LADDR, 32'h0);
    chk(rdat, 32'h0301_0020);
    // fast read, partial sector of one byte, then a prompt untalk
    apb(1'h1, A_CMD, 32'ha);
    rd_byte <= 8'h5a;
    rd_valid <= 1'h1;
    @(posedge pclk);
    rd_valid <= 1'h0;
    while (cnt !== 4'h8) @(posedge pclk);
    untalk <= 1'h1;
    @(posedge pclk);
    untalk <= 1'h0;
    wt;
    chk({tx_eot, got[7], rdat[15:0]}, 32'h005a_0000);
    // fast read aborted by a data error ends with a dummy eot byte
    apb(1'h1, A_CMD, 32'ha);
    rd_data_err <= 1'h1;
    @(posedge pclk);
    rd_data_err <= 1'h0;
    wt;
    chk({tx_eot, got[0], rdat[15:0]}, 32'h0100_0108);
    apb(1'h1, A_PARAM, 32'hb);
    apb(1'h1, A_CMD, 32'h6);
    wt;
    apb(1'h0, A_MASK, 32'h0);
    chk(32'(rdat[3:0]), 32'hb);
    univ_clear <= 1'h1;
    @(posedge pclk);
    univ_clear <= 1'h0;
    apb(1'h0, A_MASK, 32'h0);
    chk(32'(rdat[3:0]), 32'(MASK_RST));
    apb(1'h0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    wrap_up;
  end
endmodule : dci_cmd_tb_top
